/* File: include/lsm_defines.vh */
// lsm_defines.vh: constants of the lane sample mapper.
// Assumes it is included by bare name from every design file.
`ifndef LSM_DEFINES_VH
`define LSM_DEFINES_VH

// ----------------------------------------------------------------------
// field widths
// ----------------------------------------------------------------------
`define LSM_SAMP_W      15
`define LSM_WORD_W      16
`define LSM_RAW_W       12
`define LSM_LANE_W      32
`define LSM_LANES       8
`define LSM_MODE_W      7
`define LSM_CLS_W       4
`define LSM_OCT_W       3

// ----------------------------------------------------------------------
// octets carried per lane and frame
// ----------------------------------------------------------------------
`define LSM_OCT_TWO     3'h2
`define LSM_OCT_FOUR    3'h4

// ----------------------------------------------------------------------
// lane counts and lane masks
// ----------------------------------------------------------------------
`define LSM_ACT_LANE0   8'h01
`define LSM_ACT_SIX     8'h3F
`define LSM_CNT_ZERO    4'h0
`define LSM_CNT_ONE     4'h1
`define LSM_CNT_TWO     4'h2
`define LSM_CNT_FOUR    4'h4
`define LSM_CNT_EIGHT   4'h8

// ----------------------------------------------------------------------
// link mode select codes
// ----------------------------------------------------------------------
`define LSM_M13         7'h0D
`define LSM_M14         7'h0E
`define LSM_M15         7'h0F
`define LSM_M16         7'h10
`define LSM_M19         7'h13
`define LSM_M20         7'h14
`define LSM_M21         7'h15
`define LSM_M22         7'h16
`define LSM_M23         7'h17
`define LSM_M24         7'h18
`define LSM_M25         7'h19
`define LSM_M36         7'h24
`define LSM_M38         7'h26
`define LSM_M39         7'h27
`define LSM_M42         7'h2A
`define LSM_M43         7'h2B
`define LSM_M46         7'h2E
`define LSM_M48         7'h30
`define LSM_M49         7'h31
`define LSM_M52         7'h34
`define LSM_M55         7'h37
`define LSM_M56         7'h38
`define LSM_M57         7'h39
`define LSM_M58         7'h3A
`define LSM_M59         7'h3B
`define LSM_M60         7'h3C
`define LSM_M61         7'h3D
`define LSM_M62         7'h3E
`define LSM_M64         7'h40
`define LSM_M65         7'h41
`define LSM_M66         7'h42
`define LSM_M67         7'h43
`define LSM_M68         7'h44
`define LSM_M69         7'h45
`define LSM_M70         7'h46
`define LSM_M71         7'h47

// ----------------------------------------------------------------------
// mapping classes
// ----------------------------------------------------------------------
`define LSM_CLS_NONE    4'h0
`define LSM_CLS_D8_2L   4'h1
`define LSM_CLS_D8_4L   4'h2
`define LSM_CLS_D8_8L   4'h3
`define LSM_CLS_D8_16L  4'h4
`define LSM_CLS_S12     4'h5
`define LSM_CLS_D12     4'h6
`define LSM_CLS_S4_4L   4'h7
`define LSM_CLS_S4_8L   4'h8
`define LSM_CLS_S8_2L   4'h9
`define LSM_CLS_S8_4L   4'hA
`define LSM_CLS_S4_16L  4'hB

`endif

/* File: rtl/lsm_lane_mapper.v */
// lsm_lane_mapper.v: transport-layer lane mapper for a dual-channel converter.
// Assumes all inputs come from logic on ref_clk_i (the frame clock) and that
// the serializer sends each lane word octet 0 first, taken from bits [31:24].
`timescale 1ns/1ps
`include "lsm_defines.vh"

module lsm_lane_mapper (
  // clock and reset
  input  wire                               ref_clk_i,
  input  wire                               rstn_i,
  // mode and frame strobe
  input  wire [`LSM_MODE_W-1:0]             link_mode_select_i,
  input  wire                               frame_valid_i,
  // decimated samples
  input  wire [`LSM_LANES*`LSM_SAMP_W-1:0]  chan_a_inphase_sample_i,
  input  wire [`LSM_LANES*`LSM_SAMP_W-1:0]  chan_a_quad_sample_i,
  input  wire [4*`LSM_SAMP_W-1:0]           chan_b_inphase_sample_i,
  input  wire [4*`LSM_SAMP_W-1:0]           chan_b_quad_sample_i,
  // over-range flags, dual channel
  input  wire [3:0]                         chan_a_inphase_overrange_i,
  input  wire [3:0]                         chan_a_quad_overrange_i,
  input  wire [3:0]                         chan_b_inphase_overrange_i,
  input  wire [3:0]                         chan_b_quad_overrange_i,
  // over-range flags, single channel
  input  wire [`LSM_LANES-1:0]              inphase_overrange_flag_i,
  input  wire [`LSM_LANES-1:0]              quad_overrange_flag_i,
  // bypass samples
  input  wire [16*`LSM_RAW_W-1:0]           raw_sample_i,
  // lane words
  output reg  [`LSM_LANES*`LSM_LANE_W-1:0]  lane_group_a_o,
  output reg  [`LSM_LANES*`LSM_LANE_W-1:0]  lane_group_b_o,
  // lane status
  output reg  [`LSM_LANES-1:0]              lane_active_a_o,
  output reg  [`LSM_LANES-1:0]              lane_active_b_o,
  output reg  [`LSM_OCT_W-1:0]              lane_octets_o,
  output reg                                frame_valid_o,
  output reg                                mode_supported_o
);

  localparam LW  = `LSM_LANE_W;
  localparam WW  = `LSM_WORD_W;
  localparam SW  = `LSM_SAMP_W;
  localparam RW  = `LSM_RAW_W;
  localparam NL  = `LSM_LANES;
  localparam PKW = 4*`LSM_RAW_W;

  // ----------------------------------------------------------------------
  // lane counts and masks per class
  // ----------------------------------------------------------------------
  localparam [NL-1:0] ACT_LANE0 = `LSM_ACT_LANE0;
  localparam [NL-1:0] ACT_SIX   = `LSM_ACT_SIX;
  localparam [3:0]    CNT_ZERO  = `LSM_CNT_ZERO;
  localparam [3:0]    CNT_ONE   = `LSM_CNT_ONE;
  localparam [3:0]    CNT_TWO   = `LSM_CNT_TWO;
  localparam [3:0]    CNT_FOUR  = `LSM_CNT_FOUR;
  localparam [3:0]    CNT_EIGHT = `LSM_CNT_EIGHT;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [`LSM_CLS_W-1:0]  cls;
  reg  [NL*LW-1:0]       lane_a_next;
  reg  [NL*LW-1:0]       lane_b_next;
  reg  [NL-1:0]          act_a_next;
  reg  [NL-1:0]          act_b_next;
  reg  [`LSM_OCT_W-1:0]  oct_next;
  reg  [3:0]             half_lanes;
  reg  [3:0]             n_lanes;
  reg                    pair_flag;
  integer                i;
  integer                j;

  wire [4*WW-1:0]        dai_word;
  wire [4*WW-1:0]        daq_word;
  wire [4*WW-1:0]        dbi_word;
  wire [4*WW-1:0]        dbq_word;
  wire [NL*WW-1:0]       si_word;
  wire [NL*WW-1:0]       si_pair_word;
  wire [NL*WW-1:0]       sq_word;
  wire [NL*WW-1:0]       sq_pair_word;
  wire [4*PKW-1:0]       pk_in;
  wire [4*PKW-1:0]       pk_out;
  wire                   bypass_dual;

  genvar g;
  genvar k;

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  always @* begin
    case (link_mode_select_i)
      `LSM_M13, `LSM_M39, `LSM_M56, `LSM_M59, `LSM_M66, `LSM_M68:
        cls = `LSM_CLS_D8_2L;
      `LSM_M14, `LSM_M49, `LSM_M57, `LSM_M60, `LSM_M67:
        cls = `LSM_CLS_D8_4L;
      `LSM_M15, `LSM_M55, `LSM_M58:
        cls = `LSM_CLS_D8_8L;
      `LSM_M16:
        cls = `LSM_CLS_D8_16L;
      `LSM_M19, `LSM_M42:
        cls = `LSM_CLS_S12;
      `LSM_M20, `LSM_M43:
        cls = `LSM_CLS_D12;
      `LSM_M21, `LSM_M36:
        cls = `LSM_CLS_S4_4L;
      `LSM_M22, `LSM_M46:
        cls = `LSM_CLS_S4_8L;
      `LSM_M23, `LSM_M38, `LSM_M61, `LSM_M64, `LSM_M69, `LSM_M71:
        cls = `LSM_CLS_S8_2L;
      `LSM_M24, `LSM_M48, `LSM_M62, `LSM_M65, `LSM_M70:
        cls = `LSM_CLS_S8_4L;
      `LSM_M25, `LSM_M52:
        cls = `LSM_CLS_S4_16L;
      default:
        cls = `LSM_CLS_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // 16-bit words: sample high, flag in bit 0
  // ----------------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dual_word
      assign dai_word[g*WW +: WW] = {chan_a_inphase_sample_i[g*SW +: SW],
                                     chan_a_inphase_overrange_i[g]};
      assign daq_word[g*WW +: WW] = {chan_a_quad_sample_i[g*SW +: SW],
                                     chan_a_quad_overrange_i[g]};
      assign dbi_word[g*WW +: WW] = {chan_b_inphase_sample_i[g*SW +: SW],
                                     chan_b_inphase_overrange_i[g]};
      assign dbq_word[g*WW +: WW] = {chan_b_quad_sample_i[g*SW +: SW],
                                     chan_b_quad_overrange_i[g]};
    end
    for (g = 0; g < NL; g = g + 1) begin : g_single_word
      assign si_word[g*WW +: WW]      = {chan_a_inphase_sample_i[g*SW +: SW],
                                         inphase_overrange_flag_i[g]};
      assign sq_word[g*WW +: WW]      = {chan_a_quad_sample_i[g*SW +: SW],
                                         quad_overrange_flag_i[g]};
      // samples 2k and 2k+1 share flag k
      assign si_pair_word[g*WW +: WW] = {chan_a_inphase_sample_i[g*SW +: SW],
                                         inphase_overrange_flag_i[g/2]};
      assign sq_pair_word[g*WW +: WW] = {chan_a_quad_sample_i[g*SW +: SW],
                                         quad_overrange_flag_i[g/2]};
    end
  endgenerate

  // ----------------------------------------------------------------------
  // 12-bit packing: four packers, three lanes each
  // ----------------------------------------------------------------------
  assign bypass_dual = (cls == `LSM_CLS_D12);

  // packer p: group p/2, lanes 3*(p%2) up; single takes every other sample
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pk
      for (k = 0; k < 4; k = k + 1) begin : g_pk_in
        assign pk_in[g*PKW + k*RW +: RW] = bypass_dual ?
          raw_sample_i[(8*(g/2) + 4*(g%2) + k)*RW +: RW] :
          raw_sample_i[(8*(g%2) + 2*k + g/2)*RW +: RW];
      end
      lsm_pack12 #(
        .RAW_W  (RW),
        .N_SAMP (4),
        .WORD_W (WW)
      ) u_pack (
        .samp_i   (pk_in[g*PKW +: PKW]),
        .packed_o (pk_out[g*PKW +: PKW])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // lane mapping per class
  // ----------------------------------------------------------------------
  always @* begin
    lane_a_next = {NL*LW{1'b0}};
    lane_b_next = {NL*LW{1'b0}};
    act_a_next  = {NL{1'b0}};
    act_b_next  = {NL{1'b0}};
    oct_next    = `LSM_OCT_TWO;
    half_lanes  = CNT_ZERO;
    n_lanes     = CNT_ZERO;
    pair_flag   = 1'b0;
    case (cls)
      `LSM_CLS_D8_2L: begin
        // octets 0-1 carry I, octets 2-3 carry Q
        lane_a_next[0 +: LW] = {dai_word[0 +: WW], daq_word[0 +: WW]};
        lane_b_next[0 +: LW] = {dbi_word[0 +: WW], dbq_word[0 +: WW]};
        act_a_next           = ACT_LANE0;
        act_b_next           = ACT_LANE0;
        oct_next             = `LSM_OCT_FOUR;
      end
      `LSM_CLS_D8_4L: begin
        half_lanes = CNT_ONE;
      end
      `LSM_CLS_D8_8L: begin
        half_lanes = CNT_TWO;
      end
      `LSM_CLS_D8_16L: begin
        half_lanes = CNT_FOUR;
      end
      `LSM_CLS_S12, `LSM_CLS_D12: begin
        for (i = 0; i < 2; i = i + 1) begin
          for (j = 0; j < 3; j = j + 1) begin
            lane_a_next[(3*i+j)*LW + WW +: WW] =
              pk_out[i*PKW + (2-j)*WW +: WW];
            lane_b_next[(3*i+j)*LW + WW +: WW] =
              pk_out[(2+i)*PKW + (2-j)*WW +: WW];
          end
        end
        act_a_next = ACT_SIX;
        act_b_next = ACT_SIX;
      end
      `LSM_CLS_S8_2L: begin
        n_lanes = CNT_ONE;
      end
      `LSM_CLS_S4_4L: begin
        n_lanes = CNT_TWO;
      end
      `LSM_CLS_S8_4L: begin
        n_lanes = CNT_TWO;
      end
      `LSM_CLS_S4_8L: begin
        n_lanes = CNT_FOUR;
      end
      `LSM_CLS_S4_16L: begin
        n_lanes   = CNT_EIGHT;
        pair_flag = 1'b1;
      end
      default: begin
        lane_a_next = {NL*LW{1'b0}};
      end
    endcase

    // dual decimated: I words first, then Q words, per group
    for (i = 0; i < 4; i = i + 1) begin
      if (i < half_lanes) begin
        lane_a_next[i*LW + WW +: WW]              = dai_word[i*WW +: WW];
        lane_a_next[(i+half_lanes)*LW + WW +: WW] = daq_word[i*WW +: WW];
        lane_b_next[i*LW + WW +: WW]              = dbi_word[i*WW +: WW];
        lane_b_next[(i+half_lanes)*LW + WW +: WW] = dbq_word[i*WW +: WW];
        act_a_next[i]                             = 1'b1;
        act_a_next[i+half_lanes]                  = 1'b1;
        act_b_next[i]                             = 1'b1;
        act_b_next[i+half_lanes]                  = 1'b1;
      end
    end

    // single decimated: I on group A, Q on group B
    for (i = 0; i < NL; i = i + 1) begin
      if (i < n_lanes) begin
        lane_a_next[i*LW + WW +: WW] = pair_flag ? si_pair_word[i*WW +: WW]
                                                 : si_word[i*WW +: WW];
        lane_b_next[i*LW + WW +: WW] = pair_flag ? sq_pair_word[i*WW +: WW]
                                                 : sq_word[i*WW +: WW];
        act_a_next[i]                = 1'b1;
        act_b_next[i]                = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // output registers, octet 0 in the top byte of each lane word
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lane_group_a_o   <= {NL*LW{1'b0}};
      lane_group_b_o   <= {NL*LW{1'b0}};
      lane_active_a_o  <= {NL{1'b0}};
      lane_active_b_o  <= {NL{1'b0}};
      lane_octets_o    <= `LSM_OCT_TWO;
      frame_valid_o    <= 1'b0;
      mode_supported_o <= 1'b0;
    end else begin
      frame_valid_o    <= frame_valid_i;
      mode_supported_o <= (cls != `LSM_CLS_NONE);
      // words hold between frames so the serializer sees stable data
      if (frame_valid_i) begin
        lane_group_a_o  <= lane_a_next;
        lane_group_b_o  <= lane_b_next;
        lane_active_a_o <= act_a_next;
        lane_active_b_o <= act_b_next;
        lane_octets_o   <= oct_next;
      end
    end
  end

endmodule // lsm_lane_mapper

/* File: rtl/lsm_pack12.v */
// lsm_pack12.v: packs four 12-bit samples back to back into three lanes.
// Assumes samples arrive flat, sample 0 in the low bits; purely combinational.
`timescale 1ns/1ps
`include "lsm_defines.vh"

module lsm_pack12 #(
  parameter RAW_W  = `LSM_RAW_W,
  parameter N_SAMP = 4,
  parameter WORD_W = `LSM_WORD_W
) (
  // samples in
  input  wire [N_SAMP*RAW_W-1:0]       samp_i,
  // packed lane words, lane 0 in the high bits
  output wire [N_SAMP*RAW_W-1:0]       packed_o
);

  genvar k;

  // ----------------------------------------------------------------------
  // sample 0 first, msb first
  // ----------------------------------------------------------------------
  generate
    for (k = 0; k < N_SAMP; k = k + 1) begin : g_pack
      assign packed_o[(N_SAMP-k)*RAW_W-1 -: RAW_W] = samp_i[k*RAW_W +: RAW_W];
    end
  endgenerate

endmodule // lsm_pack12

/* File: verif/lsm_lane_mapper_checker.sv */
// lsm_lane_mapper_checker.sv: port assertions for the lane mapper.
// Assumes one clock domain and binding to lsm_lane_mapper.
`timescale 1ns/1ps

module lsm_mapper_chk (
  input wire         ref_clk_i,
  input wire         rstn_i,
  input wire [6:0]   link_mode_select_i,
  input wire         frame_valid_i,
  input wire [119:0] chan_a_inphase_sample_i,
  input wire [119:0] chan_a_quad_sample_i,
  input wire [3:0]   chan_a_inphase_overrange_i,
  input wire [3:0]   chan_a_quad_overrange_i,
  input wire [7:0]   inphase_overrange_flag_i,
  input wire [7:0]   quad_overrange_flag_i,
  input wire [191:0] raw_sample_i,
  input wire [255:0] lane_group_a_o,
  input wire [255:0] lane_group_b_o,
  input wire [7:0]   lane_active_a_o,
  input wire [7:0]   lane_active_b_o,
  input wire [2:0]   lane_octets_o,
  input wire         frame_valid_o,
  input wire         mode_supported_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire [6:0]   m = link_mode_select_i;
  wire         f = frame_valid_i;
  wire [119:0] ia = chan_a_inphase_sample_i;
  wire [119:0] qa = chan_a_quad_sample_i;
  function automatic logic mapped(input logic [6:0] c);
    mapped = c inside {7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
      7'h18, 7'h19, 7'h24, 7'h26, 7'h27, 7'h2A, 7'h2B, 7'h2E, 7'h30, 7'h31, 7'h34,
      7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h40, 7'h41, 7'h42,
      7'h43, 7'h44, 7'h45, 7'h46, 7'h47};
  endfunction
  a_mode_flag: assert property ($past(rstn_i) |-> mode_supported_o == mapped($past(m)))
    else $error("mode flag wrong");
  a_lanes_hold: assert property (!f |=> $stable(lane_group_a_o) && $stable(lane_octets_o))
    else $error("lanes changed without frame");
  a_dual_pair: assert property (f && m inside {7'h0D, 7'h27, 7'h38, 7'h3B, 7'h42, 7'h44}
    |=> lane_octets_o == 3'h4 && lane_group_a_o[31:0] == {$past(ia[14:0]),
    $past(chan_a_inphase_overrange_i[0]), $past(qa[14:0]), $past(chan_a_quad_overrange_i[0])})
    else $error("dual two lane word wrong");
  a_dual4_quad: assert property (f && m inside {7'h0E, 7'h31, 7'h39, 7'h3C, 7'h43}
    |=> lane_active_a_o == 8'h03 && lane_group_a_o[63:32] ==
    {$past(qa[14:0]), $past(chan_a_quad_overrange_i[0]), 16'h0000})
    else $error("dual four lane quad wrong");
  a_dual16_quad: assert property (f && m == 7'h10 |=> lane_active_b_o == 8'hFF &&
    lane_group_a_o[159:144] == {$past(qa[14:0]), $past(chan_a_quad_overrange_i[0])})
    else $error("dual sixteen lane quad wrong");
  a_single_quad: assert property (f && m inside {7'h17, 7'h26, 7'h3D, 7'h40, 7'h45, 7'h47}
    |=> lane_active_b_o == 8'h01 && lane_group_b_o[31:16] ==
    {$past(qa[14:0]), $past(quad_overrange_flag_i[0])})
    else $error("single two lane quad wrong");
  a_pack_head: assert property (f && m inside {7'h13, 7'h2A} |=> lane_active_a_o == 8'h3F
    && lane_group_a_o[31:16] == {$past(raw_sample_i[11:0]), $past(raw_sample_i[35:32])})
    else $error("bypass head wrong");
  a_pair_flag: assert property (f && m inside {7'h19, 7'h34} |=>
    lane_group_a_o[63:48] == {$past(ia[29:15]), $past(inphase_overrange_flag_i[0])})
    else $error("shared flag wrong");
  a_low_zero: assert property (frame_valid_o && lane_octets_o == 3'h2 |->
    lane_group_a_o[15:0] == 16'h0000 && lane_group_b_o[15:0] == 16'h0000)
    else $error("unused octets not zero");
endmodule // lsm_mapper_chk

bind lsm_lane_mapper lsm_mapper_chk u_chk (.ref_clk_i, .rstn_i, .link_mode_select_i,
  .frame_valid_i, .chan_a_inphase_sample_i, .chan_a_quad_sample_i,
  .chan_a_inphase_overrange_i, .chan_a_quad_overrange_i, .inphase_overrange_flag_i,
  .quad_overrange_flag_i, .raw_sample_i, .lane_group_a_o, .lane_group_b_o,
  .lane_active_a_o, .lane_active_b_o, .lane_octets_o, .frame_valid_o, .mode_supported_o);

/* File: verif/lsm_lane_mapper_tb.sv */
// lsm_lane_mapper_tb.sv: self-checking bench for the lane mapper.
// Assumes inputs driven on falling edges, receiver model on the lanes.
`timescale 1ns/1ps

module lsm_lane_mapper_tb;
  reg          ref_clk_i = 1'b0;
  reg          rstn_i = 1'b0;
  reg  [6:0]   mode = 7'h00;
  reg          fv = 1'b0;
  reg  [119:0] ia = 120'h0;
  reg  [119:0] qa = 120'h0;
  reg  [59:0]  ib = 60'h0;
  reg  [59:0]  qb = 60'h0;
  reg  [3:0]   fai = 4'h9;
  reg  [3:0]   faq = 4'h6;
  reg  [3:0]   fbi = 4'hA;
  reg  [3:0]   fbq = 4'h5;
  reg  [7:0]   fi = 8'hB4;
  reg  [7:0]   fq = 8'h4B;
  reg  [191:0] raw = 192'h0;
  wire [255:0] la, lb, rxa, rxb;
  wire [7:0]   act_a, act_b;
  wire [2:0]   oct;
  wire         fvo, sup;
  reg  [31:0]  e [0:15];
  reg  [7:0]   eaa, eab;
  reg  [2:0]   eo;
  reg          es;
  integer      err_count = 0;
  integer      comparisons = 0;
  integer      cyc = 0;
  integer      i;
  initial forever #5 ref_clk_i = ~ref_clk_i;
  lsm_lane_mapper u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link_mode_select_i(mode),
    .frame_valid_i(fv), .chan_a_inphase_sample_i(ia), .chan_a_quad_sample_i(qa),
    .chan_b_inphase_sample_i(ib), .chan_b_quad_sample_i(qb),
    .chan_a_inphase_overrange_i(fai), .chan_a_quad_overrange_i(faq),
    .chan_b_inphase_overrange_i(fbi), .chan_b_quad_overrange_i(fbq),
    .inphase_overrange_flag_i(fi), .quad_overrange_flag_i(fq), .raw_sample_i(raw),
    .lane_group_a_o(la), .lane_group_b_o(lb), .lane_active_a_o(act_a),
    .lane_active_b_o(act_b), .lane_octets_o(oct), .frame_valid_o(fvo),
    .mode_supported_o(sup));
  lsm_rx_model u_rx (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .frame_valid_i(fvo),
    .lane_octets_i(oct), .lane_a_i(la), .lane_b_i(lb), .rx_a_o(rxa), .rx_b_o(rxb));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function [31:0] dw(input [14:0] s, input f);
    dw = {s, f, 16'h0000};
  endfunction
  task chk(input [8*8:1] nm, input [31:0] ex, input [31:0] gt);
    begin
      comparisons = comparisons + 1;
      if (gt !== ex) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", nm, ex, gt);
      end
    end
  endtask
  task clr(input s);
    begin
      for (i = 0; i < 16; i = i + 1) e[i] = 32'h0;
      eaa = 8'h00;
      eab = 8'h00;
      eo = 3'h2;
      es = s;
    end
  endtask
  task run(input [6:0] m);
    begin
      mode = m;
      fv = 1'b1;
      @(negedge ref_clk_i);
      fv = 1'b0;
      chk("valid", 1, fvo);
      chk("support", es, sup);
      chk("active_a", eaa, act_a);
      chk("active_b", eab, act_b);
      chk("octets", eo, oct);
      @(negedge ref_clk_i);
      chk("valid", 0, fvo);
      for (i = 0; i < 8; i = i + 1) begin
        chk("lane_a", e[i], la[32*i +: 32]);
        chk("lane_b", e[8+i], lb[32*i +: 32]);
        chk("rx_a", e[i], rxa[32*i +: 32]);
        chk("rx_b", e[8+i], rxb[32*i +: 32]);
      end
      $display("frame done mode %h", m);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_dual2(input [41:0] cl, input integer nc);
    integer c;
    begin
      for (c = 0; c < nc; c = c + 1) begin
        clr(1);
        e[0] = {ia[14:0], fai[0], qa[14:0], faq[0]};
        e[8] = {ib[14:0], fbi[0], qb[14:0], fbq[0]};
        eaa = 8'h01;
        eab = 8'h01;
        eo = 3'h4;
        run(cl[7*c +: 7]);
      end
    end
  endtask
  task t_dual(input integer h, input [34:0] cl, input integer nc);
    integer c, k;
    begin
      for (c = 0; c < nc; c = c + 1) begin
        clr(1);
        for (k = 0; k < h; k = k + 1) begin
          e[k] = dw(ia[15*k +: 15], fai[k]);
          e[h+k] = dw(qa[15*k +: 15], faq[k]);
          e[8+k] = dw(ib[15*k +: 15], fbi[k]);
          e[8+h+k] = dw(qb[15*k +: 15], fbq[k]);
        end
        eaa = (8'h01 << (2 * h)) - 8'h01;
        eab = eaa;
        run(cl[7*c +: 7]);
      end
    end
  endtask
  task t_single(input integer n, input [48:0] cl, input integer nc);
    integer c, k;
    begin
      for (c = 0; c < nc; c = c + 1) begin
        clr(1);
        for (k = 0; k < n; k = k + 1) begin
          e[k] = dw(ia[15*k +: 15], fi[(n == 8) ? k / 2 : k]);
          e[8+k] = dw(qa[15*k +: 15], fq[(n == 8) ? k / 2 : k]);
        end
        eaa = (8'h01 << n) - 8'h01;
        eab = eaa;
        run(cl[7*c +: 7]);
      end
    end
  endtask
  task t_bypass(input [6:0] m, input d);
    integer k, g, j;
    reg [47:0] p;
    begin
      clr(1);
      for (k = 0; k < 2; k = k + 1) begin
        for (g = 0; g < 2; g = g + 1) begin
          for (j = 0; j < 4; j = j + 1)
            p = {p[35:0], raw[12*(d ? 8*g+4*k+j : 8*k+2*j+g) +: 12]};
          e[8*g+3*k] = {p[47:32], 16'h0000};
          e[8*g+3*k+1] = {p[31:16], 16'h0000};
          e[8*g+3*k+2] = {p[15:0], 16'h0000};
        end
      end
      eaa = 8'h3F;
      eab = 8'h3F;
      run(m);
    end
  endtask
  task t_hold_b2b;
    begin
      mode = 7'h0E;
      fv = 1'b1;
      @(negedge ref_clk_i);
      mode = 7'h0A;
      chk("active_a", 8'h03, act_a);
      @(negedge ref_clk_i);
      fv = 1'b0;
      mode = 7'h13;
      chk("support", 0, sup);
      chk("active_a", 8'h00, act_a);
      chk("octets", 3'h2, oct);
      @(negedge ref_clk_i);
      chk("valid", 0, fvo);
      chk("support", 1, sup);
      chk("lane_a", 32'h0, la[31:0]);
      chk("active_a", 8'h00, act_a);
      $display("back to back and hold done");
    end
  endtask
  task t_reset;
    begin
      mode = 7'h0D;
      fv = 1'b1;
      @(negedge ref_clk_i);
      fv = 1'b0;
      chk("octets", 3'h4, oct);
      rstn_i = 1'b0;
      @(negedge ref_clk_i);
      chk("lane_a", 32'h0, la[31:0]);
      chk("active_b", 8'h00, act_b);
      chk("octets", 3'h2, oct);
      chk("support", 0, sup);
      rstn_i = 1'b1;
      $display("reset done");
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      if (i < 8) ia[15*i +: 15] = 15'h1234 + i * 15'h0A51;
      if (i < 8) qa[15*i +: 15] = 15'h6ACE - i * 15'h0397;
      if (i < 4) ib[15*i +: 15] = 15'h4C3D + i * 15'h1111;
      if (i < 4) qb[15*i +: 15] = 15'h2B71 ^ (i * 15'h0F0F);
      raw[12*i +: 12] = 12'h9C3 + i * 12'h1F7;
    end
    repeat (16) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rstn_i = 1'b1;
    t_dual2({7'h44, 7'h42, 7'h3B, 7'h38, 7'h27, 7'h0D}, 6);
    t_dual(1, {7'h43, 7'h3C, 7'h39, 7'h31, 7'h0E}, 5);
    t_dual(2, {7'h3A, 7'h37, 7'h0F}, 3);
    t_dual(4, {7'h10}, 1);
    t_bypass(7'h13, 0);
    t_bypass(7'h2A, 0);
    t_bypass(7'h14, 1);
    t_bypass(7'h2B, 1);
    t_single(2, {7'h24, 7'h15}, 2);
    t_single(4, {7'h2E, 7'h16}, 2);
    t_single(1, {7'h47, 7'h45, 7'h40, 7'h3D, 7'h26, 7'h17}, 6);
    t_single(2, {7'h46, 7'h41, 7'h3E, 7'h30, 7'h18}, 5);
    t_single(8, {7'h34, 7'h19}, 2);
    {fai, faq, fbi, fbq} = ~{fai, faq, fbi, fbq};
    t_dual(2, {7'h37}, 1);
    clr(0);
    run(7'h0A);
    t_hold_b2b;
    t_reset;
    t_dual(4, {7'h10}, 1);
    final_report;
  end
endmodule // lsm_lane_mapper_tb

/* File: verif/lsm_rx_model.sv */
// lsm_rx_model.sv: receiver model, rebuilds lane words from nibble order.
// Assumes lane words and octet count come from the mapper on ref_clk_i.
`timescale 1ns/1ps

module lsm_rx_model (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         rstn_i,
  // lanes from the mapper
  input  wire         frame_valid_i,
  input  wire [2:0]   lane_octets_i,
  input  wire [255:0] lane_a_i,
  input  wire [255:0] lane_b_i,
  // rebuilt lane words
  output reg  [255:0] rx_a_o,
  output reg  [255:0] rx_b_o
);
  integer    l;
  integer    n;
  reg [31:0] wa;
  reg [31:0] wb;
  // ----------------------------------------------------------------
  // nibble receiver
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_a_o <= 256'h0;
      rx_b_o <= 256'h0;
    end else if (frame_valid_i) begin
      for (l = 0; l < 8; l = l + 1) begin
        wa = 32'h0;
        wb = 32'h0;
        // octets ascending, high nibble first
        for (n = 0; n < 2 * lane_octets_i; n = n + 1) begin
          wa = {wa[27:0], lane_a_i[32*l+28-4*n +: 4]};
          wb = {wb[27:0], lane_b_i[32*l+28-4*n +: 4]};
        end
        rx_a_o[32*l +: 32] <= wa << (4 * (8 - 2 * lane_octets_i));
        rx_b_o[32*l +: 32] <= wb << (4 * (8 - 2 * lane_octets_i));
      end
    end
  end
endmodule // lsm_rx_model
